// *** rtl/dsrcf_map.svh ***
// register map, field positions and timing constants for the disk command front
`ifndef DSRCF_MAP_SVH
`define DSRCF_MAP_SVH
`define DSRCF_ST_BUSY 7
`define DSRCF_ST_READY 6
`define DSRCF_ST_FAULT 5
`define DSRCF_ST_SEEK 4
`define DSRCF_ST_DRQ 3
`define DSRCF_ST_CORR 2
`define DSRCF_ST_INDEX 1
`define DSRCF_ST_ERR 0
`define DSRCF_ERR_ABORT 2
`define DSRCF_DIAG_OK 8'h01
`define DSRCF_CMD_POWER_QUERY 8'he5
`define DSRCF_CMD_DOWNLOAD_PIO 8'h92
`define DSRCF_CMD_DOWNLOAD_DMA 8'h93
`define DSRCF_PWR_STANDBY_CNT 8'hff
`define DSRCF_PWR_ACTIVE_CNT 8'hff
`define DSRCF_CLK_MHZ 250
`define DSRCF_MIN_COMPLETION_TIME_LIMIT_MS 50
`define DSRCF_MIN_ERC_MS 6500
`define DSRCF_POR_WINDOW_MS 500
`define DSRCF_COMINIT_MS 10
`define DSRCF_CYC_PER_MS (`DSRCF_CLK_MHZ * 1000)
`define DSRCF_POR_WINDOW_CYC (`DSRCF_POR_WINDOW_MS * `DSRCF_CYC_PER_MS)
`define DSRCF_COMINIT_CYC (`DSRCF_COMINIT_MS * `DSRCF_CYC_PER_MS)
`define DSRCF_RESET_CYC 8'h04
`endif

// *** rtl/dsrcf_pkg.sv ***
// types shared by the disk command front
package dsrcf_pkg;
  typedef enum logic [3:0] {
    DSRCF_IDLE = 4'b0001,
    DSRCF_EXEC = 4'b0010,
    DSRCF_SPIN = 4'b0100,
    DSRCF_RST = 4'b1000
  } dsrcf_state_t;
  typedef logic [7:0] dsrcf_byte_t;
endpackage

// *** rtl/dsrcf_ctl_if.sv ***
// carrier between front end and its timing-limit checker
`timescale 1ns/10ps
`default_nettype none
interface dsrcf_ctl_if;
  import dsrcf_pkg::*;
  logic [15:0] limit_ms;
  logic is_erc;
  logic too_short;
  logic [15:0] eff_ms;
  modport front (output limit_ms, output is_erc, input too_short, input eff_ms);
  modport chk (input limit_ms, input is_erc, output too_short, output eff_ms);
endinterface
`default_nettype wire

// *** rtl/dsrcf_limit_chk.sv ***
// time-limit checker: clamps completion limit, flags short recovery limits
`timescale 1ns/10ps
`include "dsrcf_map.svh"
`default_nettype none
module dsrcf_limit_chk (
  dsrcf_ctl_if.chk ctl
);
  import dsrcf_pkg::*;
  wire logic below_completion_time_limit;
  wire logic below_erc;
  // small limits: raised for completion, refused for recovery
  assign below_completion_time_limit = ctl.limit_ms < 16'(`DSRCF_MIN_COMPLETION_TIME_LIMIT_MS);
  assign below_erc = ctl.limit_ms < 16'(`DSRCF_MIN_ERC_MS);
  assign ctl.too_short = ctl.is_erc & below_erc;
  assign ctl.eff_ms = (!ctl.is_erc && below_completion_time_limit) ? 16'(`DSRCF_MIN_COMPLETION_TIME_LIMIT_MS)
                      : ctl.limit_ms;
endmodule
`default_nettype wire

// *** rtl/dsrcf_front.sv ***
// command and status front end of the drive behind the shadow registers
`timescale 1ns/10ps
`include "dsrcf_map.svh"
`default_nettype none
module dsrcf_front #(
  parameter int POR_WINDOW_CYC = `DSRCF_POR_WINDOW_CYC,
  parameter int COMINIT_CYC = `DSRCF_COMINIT_CYC
) (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic cmd_wr,
  input wire dsrcf_pkg::dsrcf_byte_t cmd_code,
  input wire logic [15:0] cmd_limit_ms,
  input wire logic cmd_limit_is_erc,
  input wire logic cmd_streaming,
  input wire logic software_reset_bit,
  input wire logic comreset_pin,
  input wire logic standby,
  input wire logic security_locked,
  input wire logic spindle_ready_pin,
  input wire logic exec_done,
  input wire logic status_rd,
  input wire logic alt_status_rd,
  output logic [7:0] status,
  output logic [7:0] status_mirror_no_ack,
  output logic [7:0] error_reg,
  output logic [7:0] sector_count,
  output logic [15:0] eff_limit_ms,
  output logic exec_start,
  output logic intrq,
  output logic cominit
);
  import dsrcf_pkg::*;
  dsrcf_ctl_if ctl ();
  dsrcf_limit_chk u_chk (.ctl(ctl));
  dsrcf_state_t state_q, state_d;
  logic [2:0] comreset_sync_q, spin_sync_q;
  logic comreset_q, spin_q;
  logic software_reset_bit_q;
  logic [31:0] por_cnt_q;
  logic [31:0] cominit_cnt_q;
  logic cominit_pend_q;
  logic [7:0] rst_cnt_q;
  logic busy_q, err_q, intrq_q;
  logic [7:0] status_busy;
  logic [7:0] status_idle;
  logic [7:0] error_q, count_q;
  logic [15:0] eff_q;
  logic start_q;
  dsrcf_byte_t code_q;
  wire logic por_window;
  wire logic comreset_rise;
  wire logic abort_now;
  wire logic is_download;
  wire logic needs_spin;
  wire logic done_now;
  wire logic [7:0] status_word;
  // limit fields of the incoming command go to the checker
  assign ctl.limit_ms = cmd_limit_ms;
  assign ctl.is_erc = cmd_limit_is_erc;
  // pin inputs: change accepted once second and third stages agree
  // second stage keeps a metastable first stage out of the logic
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      comreset_sync_q <= 3'h0;
      spin_sync_q <= 3'h0;
      comreset_q <= 1'b0;
      spin_q <= 1'b0;
    end else begin
      comreset_sync_q <= {comreset_sync_q[1:0], comreset_pin};
      spin_sync_q <= {spin_sync_q[1:0], spindle_ready_pin};
      if (comreset_sync_q[1] == comreset_sync_q[2]) comreset_q <= comreset_sync_q[2];
      if (spin_sync_q[1] == spin_sync_q[2]) spin_q <= spin_sync_q[2];
    end
  end
  assign comreset_rise = (comreset_sync_q[1] == comreset_sync_q[2]) &
                         comreset_sync_q[2] & ~comreset_q;
  // command decode; downloads refused while locked
  assign is_download = (cmd_code == `DSRCF_CMD_DOWNLOAD_PIO) |
                       (cmd_code == `DSRCF_CMD_DOWNLOAD_DMA);
  assign abort_now = (is_download & security_locked) | ctl.too_short;
  assign needs_spin = standby & (cmd_streaming | cmd_limit_is_erc);
  assign done_now = (state_q == DSRCF_EXEC) & exec_done;
  // sequencer: spin-up wait ignores the time limit on purpose
  always_comb begin
    state_d = state_q;
    case (state_q)
      DSRCF_IDLE: begin
        // an abort leaves the sequencer idle and busy clear
        if (cmd_wr && !abort_now) begin
          state_d = needs_spin ? DSRCF_SPIN : DSRCF_EXEC;
        end
      end
      DSRCF_SPIN: begin
        if (spin_q) state_d = DSRCF_EXEC;
      end
      DSRCF_EXEC: begin
        if (exec_done) state_d = DSRCF_IDLE;
      end
      DSRCF_RST: begin
        // held here for as long as the host keeps the reset bit set
        if (rst_cnt_q == 8'h00 && !software_reset_bit_q) state_d = DSRCF_IDLE;
      end
      default: state_d = DSRCF_IDLE;
    endcase
    if (comreset_rise || software_reset_bit_q) state_d = DSRCF_RST;
  end
  // state, registered software reset bit and reset dwell
  // dwell reloads while the reset bit is held and runs once it drops
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      state_q <= DSRCF_RST;
      software_reset_bit_q <= 1'b0;
      rst_cnt_q <= `DSRCF_RESET_CYC;
    end else begin
      state_q <= state_d;
      software_reset_bit_q <= software_reset_bit;
      if (state_q != DSRCF_RST || software_reset_bit_q) rst_cnt_q <= `DSRCF_RESET_CYC;
      else if (rst_cnt_q != 8'h00) rst_cnt_q <= rst_cnt_q - 8'h01;
    end
  end
  // power-on window; comreset inside it may be answered late
  assign por_window = por_cnt_q < 32'(POR_WINDOW_CYC);
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      por_cnt_q <= 32'h0;
      cominit_cnt_q <= 32'h0;
      cominit_pend_q <= 1'b0;
      cominit <= 1'b0;
    end else begin
      if (por_window) por_cnt_q <= por_cnt_q + 32'h1;
      // answer is a single-cycle pulse
      cominit <= 1'b0;
      // a fresh link reset restarts the count of a pending answer
      if (comreset_rise) begin
        cominit_pend_q <= 1'b1;
        cominit_cnt_q <= 32'h0;
      end else if (cominit_pend_q) begin
        cominit_cnt_q <= cominit_cnt_q + 32'h1;
        // late answer held until window closes
        if (!por_window && cominit_cnt_q + 32'h1 >= 32'(COMINIT_CYC) / 32'h2) begin
          cominit <= 1'b1;
          cominit_pend_q <= 1'b0;
        end
      end
    end
  end
  // status, error, count and interrupt
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      busy_q <= 1'b1;
      err_q <= 1'b0;
      intrq_q <= 1'b0;
      error_q <= 8'h00;
      count_q <= 8'h00;
      eff_q <= 16'h0000;
      start_q <= 1'b0;
      code_q <= 8'h00;
    end else begin
      // start is a one-cycle pulse; events below may override a read
      start_q <= 1'b0;
      if (status_rd) intrq_q <= 1'b0;
      if (state_q == DSRCF_RST) begin
        busy_q <= 1'b1;
        intrq_q <= 1'b0;
        if (state_d == DSRCF_IDLE) begin
          busy_q <= 1'b0;
          err_q <= 1'b0;
          error_q <= `DSRCF_DIAG_OK; // diagnostic code as dwell ends
        end
      end else if (state_q == DSRCF_IDLE && cmd_wr) begin
        code_q <= cmd_code;
        eff_q <= ctl.eff_ms;
        if (abort_now) begin
          err_q <= 1'b1;
          error_q <= 8'h01 << `DSRCF_ERR_ABORT;
          intrq_q <= 1'b1;
        end else begin
          busy_q <= 1'b1;
          err_q <= 1'b0;
          error_q <= 8'h00;
          start_q <= ~needs_spin;
        end
      end else if (state_q == DSRCF_SPIN && spin_q) begin
        start_q <= 1'b1;
      end else if (done_now) begin
        busy_q <= 1'b0;
        intrq_q <= 1'b1; // completion beats a same-cycle read
        if (code_q == `DSRCF_CMD_POWER_QUERY) begin
          count_q <= standby ? `DSRCF_PWR_STANDBY_CNT : `DSRCF_PWR_ACTIVE_CNT;
        end
      end
    end
  end
  // busy hides other bits so a stale view is never shown
  always_comb begin
    status_busy = 8'h00;
    status_busy[`DSRCF_ST_BUSY] = 1'b1;
  end
  // settled view; no data phase here, so data request stays low
  always_comb begin
    status_idle = 8'h00;
    status_idle[`DSRCF_ST_READY] = 1'b1;
    status_idle[`DSRCF_ST_FAULT] = 1'b0; // fault never reported
    status_idle[`DSRCF_ST_SEEK] = 1'b1; // shown even while spun down
    status_idle[`DSRCF_ST_DRQ] = 1'b0;
    status_idle[`DSRCF_ST_CORR] = 1'b0; // corrected data never flagged
    status_idle[`DSRCF_ST_INDEX] = 1'b0;
    status_idle[`DSRCF_ST_ERR] = err_q;
  end
  assign status_word = busy_q ? status_busy : status_idle;
  // both views come from one word so they cannot drift apart
  assign status = status_word;
  assign status_mirror_no_ack = status_word;
  // registered results straight to the pins
  assign error_reg = error_q;
  assign sector_count = count_q;
  assign eff_limit_ms = eff_q;
  assign exec_start = start_q;
  assign intrq = intrq_q;
endmodule
`default_nettype wire

// *** tb/dsrcf_front_sva.sv ***
// port assertions for the disk command front
`timescale 1ns/10ps
`include "dsrcf_map.svh"
`default_nettype none
module dsrcf_front_sva #(
  parameter int POR_WINDOW_CYC = 100,
  parameter int COMINIT_CYC = 20
) (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic cmd_wr,
  input wire dsrcf_pkg::dsrcf_byte_t cmd_code,
  input wire logic [15:0] cmd_limit_ms,
  input wire logic cmd_limit_is_erc,
  input wire logic cmd_streaming,
  input wire logic software_reset_bit,
  input wire logic comreset_pin,
  input wire logic standby,
  input wire logic security_locked,
  input wire logic spindle_ready_pin,
  input wire logic exec_done,
  input wire logic status_rd,
  input wire logic alt_status_rd,
  input wire logic [7:0] status,
  input wire logic [7:0] status_mirror_no_ack,
  input wire logic [7:0] error_reg,
  input wire logic [7:0] sector_count,
  input wire logic [15:0] eff_limit_ms,
  input wire logic exec_start,
  input wire logic intrq,
  input wire logic cominit
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  // a write only counts while idle
  sequence s_take;
    cmd_wr && !status[7];
  endsequence
  sequence s_dl;
    cmd_code == `DSRCF_CMD_DOWNLOAD_PIO || cmd_code == `DSRCF_CMD_DOWNLOAD_DMA;
  endsequence
  a_mirror_same: assert property (status_mirror_no_ack == status)
    else $error("mirror differs");
  a_busy_masks: assert property (status[7] |-> status[6:0] == 7'h00)
    else $error("bits shown while busy");
  a_locked_dl_abort: assert property (
    s_take ##0 s_dl ##0 security_locked |=> error_reg[2] && status[0] && intrq && !exec_start)
    else $error("download ran");
  a_short_erc_abort: assert property (
    s_take ##0 cmd_limit_is_erc && cmd_limit_ms < 16'h1964 |=> error_reg[2] && !exec_start)
    else $error("short limit ran");
  a_start_next: assert property (
    s_take ##0 !standby && !security_locked && !cmd_limit_is_erc |=> exec_start)
    else $error("no start");
  a_completion_time_limit_floor: assert property (
    s_take ##0 !standby && !security_locked && !cmd_limit_is_erc |=> eff_limit_ms ==
    ($past(cmd_limit_ms) < 16'h0032 ? 16'h0032 : $past(cmd_limit_ms))) else $error("floor");
  a_alt_keeps_irq: assert property (
    intrq && alt_status_rd && !status_rd && !software_reset_bit |=> intrq)
    else $error("alt read acked");
  a_rd_clears_irq: assert property (
    intrq && status_rd && !exec_done |=> !intrq) else $error("irq kept");
  a_cominit_pulse: assert property (cominit |=> !cominit)
    else $error("cominit held");
  a_software_reset_bit_busy: assert property (
    software_reset_bit ##1 software_reset_bit ##1 software_reset_bit |=> status[7])
    else $error("no busy on reset bit");
endmodule
bind dsrcf_front dsrcf_front_sva #(.POR_WINDOW_CYC(POR_WINDOW_CYC), .COMINIT_CYC(COMINIT_CYC))
  u_sva (.ref_clk, .resetn, .cmd_wr, .cmd_code, .cmd_limit_ms, .cmd_limit_is_erc,
  .cmd_streaming, .software_reset_bit, .comreset_pin, .standby, .security_locked,
  .spindle_ready_pin, .exec_done, .status_rd, .alt_status_rd, .status, .status_mirror_no_ack,
  .error_reg, .sector_count, .eff_limit_ms, .exec_start, .intrq, .cominit);
`default_nettype wire

// *** tb/dsrcf_host_model.sv ***
// host adapter model: forwards shadow writes to the front as frames
`timescale 1ns/10ps
`default_nettype none
module dsrcf_host_model (
  input wire logic ref_clk,
  input wire logic wr_req,
  input wire logic [7:0] wr_code,
  input wire logic software_reset_bit_req,
  input wire logic busy,
  output logic cmd_wr = 1'b0,
  output logic [7:0] cmd_code = 8'h00,
  output logic software_reset_bit = 1'b0
);
  // code toggles when no frame, so a stale value never looks valid
  always @(posedge ref_clk) begin
    cmd_wr <= wr_req && !busy;
    cmd_code <= (wr_req && !busy) ? wr_code : ~cmd_code;
    software_reset_bit <= software_reset_bit_req;
  end
endmodule
`default_nettype wire

// *** tb/dsrcf_front_bench.sv ***
// self-checking bench for the disk command front
`timescale 1ns/10ps
`default_nettype none
module dsrcf_front_bench;
  logic ref_clk = 0, resetn = 0, wr_req = 0, software_reset_bit_req = 0, cmd_wr, software_reset_bit;
  logic e = 0, s = 0, comreset_pin = 0, standby = 0, locked = 0, spin = 1;
  logic exec_done = 0, status_rd = 0, alt_status_rd = 0, intrq, exec_start, cominit;
  logic [7:0] wr_code = 0, status, error_reg, sector_count, cmd_code, mirror;
  logic [15:0] lim = 0, eff_limit_ms;
  int miscompares = 0, compares = 0, starts = 0, inits = 0;
  logic [7:0] codes [4] = '{8'he5, 8'h92, 8'h93, 8'h25};
  dsrcf_host_model host (.ref_clk, .wr_req, .wr_code, .software_reset_bit_req, .busy(status[7]), .cmd_wr,
    .cmd_code, .software_reset_bit);
  dsrcf_front #(.POR_WINDOW_CYC(100), .COMINIT_CYC(20)) DUT (.ref_clk, .resetn, .cmd_wr,
    .cmd_code, .cmd_limit_ms(lim), .cmd_limit_is_erc(e), .cmd_streaming(s),
    .software_reset_bit, .comreset_pin, .standby, .security_locked(locked),
    .spindle_ready_pin(spin), .exec_done, .status_rd, .alt_status_rd, .status,
    .status_mirror_no_ack(mirror), .error_reg, .sector_count, .eff_limit_ms, .exec_start, .intrq,
    .cominit);
  // clock, reset and event counters
  initial forever #2 ref_clk = ~ref_clk;
  initial begin
    repeat (16) @(posedge ref_clk);
    resetn <= 1;
  end
  always @(posedge ref_clk) starts += (exec_start === 1'b1);
  always @(posedge ref_clk) inits += (cominit === 1'b1);
  task automatic chk(input bit ok, input string m);
    compares++;
    if (!ok) begin
      miscompares++;
      $display("CHECK FAILED %0t %s", $time, m);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  task automatic wait_idle();
    int w = 0;
    while (status[7] !== 1'b0 && w < 200) begin
      tick(1);
      w++;
    end
    chk(status[7] === 1'b0, "stuck busy");
  endtask
  // model decides abort and spin wait, then the transfer is walked
  task automatic run(input logic [7:0] c);
    int n0, ab, sw;
    n0 = starts;
    ab = (locked && (c == 8'h92 || c == 8'h93)) || (e && lim < 6500);
    sw = standby && (s || e) && !spin && !ab;
    @(posedge ref_clk) wr_req <= 1;
    wr_code <= c;
    @(posedge ref_clk) wr_req <= 0;
    tick(3); // spin-wait path starts a cycle later even with spindle ready
    if (sw) begin
      tick(20);
      chk(starts == n0 && status[7] === 1'b1, "no spin wait");
      @(posedge ref_clk) spin <= 1;
      tick(8);
    end
    chk(starts == n0 + !ab, "start count");
    if (ab) chk(error_reg === 8'h04 && status[0] === 1'b1, "no abort");
    else begin
      chk(eff_limit_ms === (!e && lim < 16'h0032 ? 16'h0032 : lim), "limit");
      @(posedge ref_clk) exec_done <= 1;
      @(posedge ref_clk) exec_done <= 0;
      tick(1);
      chk(status[7] === 1'b0 && (c != 8'he5 || sector_count === 8'hff), "done");
    end
    chk(intrq === 1'b1, "no irq");
    @(posedge ref_clk) alt_status_rd <= 1;
    @(posedge ref_clk) alt_status_rd <= 0;
    tick(1);
    chk(intrq === 1'b1, "alt read acked");
    chk(mirror === (ab ? 8'h51 : 8'h50) && status === mirror, "mirror");
    @(posedge ref_clk) status_rd <= 1;
    @(posedge ref_clk) status_rd <= 0;
    tick(1);
    chk(intrq === 1'b0, "irq kept");
  endtask
  task automatic tally_and_finish();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    tick(20000);
    miscompares++;
    tally_and_finish();
  end
  // codes, lock, standby and spindle swept; limits random
  initial begin
    void'($urandom(53610));
    tick(24);
    wait_idle();
    chk(error_reg === 8'h01 && status === 8'h50, "reset state");
    @(posedge ref_clk) comreset_pin <= 1;
    tick(30);
    chk(inits == 0, "early cominit");
    @(posedge ref_clk) comreset_pin <= 0;
    wait_idle();
    for (int i = 0; i < 16; i++) begin
      @(posedge ref_clk) locked <= i[2];
      standby <= i[3];
      spin <= !(i[3] && i[0]);
      e <= 1'($urandom % 2);
      s <= 1'($urandom % 2);
      lim <= 16'($urandom % (i[1] ? 9000 : 60));
      tick(5);
      run(codes[i % 4]);
    end
    chk(inits == 1, "late cominit");
    @(posedge ref_clk) locked <= 1;
    wr_req <= 1;
    wr_code <= 8'h92;
    @(posedge ref_clk) wr_req <= 0;
    tick(3);
    chk(intrq === 1'b1, "abort irq");
    @(posedge ref_clk) software_reset_bit_req <= 1;
    tick(5);
    chk(status === 8'h80 && intrq === 1'b0, "software_reset_bit");
    @(posedge ref_clk) software_reset_bit_req <= 0;
    wait_idle();
    @(posedge ref_clk) comreset_pin <= 1;
    tick(8);
    chk(status[7] === 1'b1, "comreset");
    tick(120);
    chk(inits == 2, "cominit");
    @(posedge ref_clk) comreset_pin <= 0;
    wait_idle();
    tally_and_finish();
  end
endmodule
`default_nettype wire
